// *** rtl/ssp_top.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------
// fifo with registered flags
// ---------------------------------------------------------
module ssp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   output logic [CW-1:0] count_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic push;
   logic pop;
   logic [CW-1:0] next_count;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end

   assign push = in_valid_in & in_ready_out;
   assign pop = out_ready_in & out_valid_out;
   assign next_count = count_out + CW'(push) - CW'(pop);
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count_out <= '0;
         in_ready_out <= 1'b1;
         out_valid_out <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + PW'(1);
         if (pop)
            rd_ptr <= rd_ptr + PW'(1);
         count_out <= next_count;
         in_ready_out <= next_count != CW'(DEPTH);
         out_valid_out <= next_count != '0;
      end
   end

   // storage needs no reset
   always_ff @(posedge clk_in)
   begin
      if (push)
         mem[wr_ptr] <= in_data_in;
   end
endmodule

// ---------------------------------------------------------
// synchronous serial port
// ---------------------------------------------------------
module ssp_top #(
   parameter int DEPTH = ssp_pkg::FIFO_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // configuration
   input wire logic enable_in,
   input wire logic master_in,
   input wire logic [1:0] format_in,
   input wire logic [3:0] data_size_m1_in,
   input wire logic clock_polarity_in,
   input wire logic clock_phase_in,
   input wire logic loopback_in,
   input wire logic [7:0] clock_prescale_divisor_in,
   input wire logic [7:0] serial_clock_rate_in,
   input wire logic [3:0] interrupt_mask_in,
   input wire logic [1:0] status_clear_in,
   // transmit words
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [15:0] tx_data_in,
   // receive words
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output logic [15:0] rx_data_out,
   // status
   output logic [3:0] raw_interrupt_status_out,
   output logic [3:0] masked_interrupt_status_out,
   output logic irq_out,
   output logic busy_out,
   // serial pins
   input wire logic serial_clock_in,
   output logic serial_clock_out,
   output logic serial_clock_oe_out,
   input wire logic frame_select_line_in,
   output logic frame_select_line_out,
   output logic frame_select_line_oe_out,
   output logic serial_tx_line_out,
   output logic serial_tx_line_oe_out,
   input wire logic serial_rx_line_in
);
   localparam logic [CW-1:0] HALF_LEVEL = CW'(DEPTH / 2);

   ssp_pkg::ssp_state_t state;
   ssp_pkg::ssp_state_t next_state;
   logic rst_meta;
   logic rst_n;
   logic clk_meta;
   logic clk_sync;
   logic clk_prev;
   logic fss_meta;
   logic fss_sync;
   logic rx_meta;
   logic rx_sync;
   logic [6:0] pre_cnt;
   logic [7:0] rate_cnt;
   logic [6:0] half_pre;
   logic half_tick;
   logic half_b;
   logic [3:0] size_m1;
   logic [4:0] last_idx;
   logic [4:0] bit_idx;
   logic [15:0] tx_sh;
   logic [15:0] rx_sh;
   logic [15:0] aligned;
   logic idle_pol;
   logic launch_first;
   logic ev1;
   logic ev2;
   logic cap;
   logic launch;
   logic rx_bit;
   logic load;
   logic lead_done;
   logic last_bit;
   logic abort;
   logic tail_done;
   logic tx_has;
   logic [15:0] tx_word;
   logic [CW-1:0] tx_count;
   logic rx_push;
   logic [15:0] rx_word;
   logic rx_space;
   logic [CW-1:0] rx_count;
   logic [6:0] idle_cnt;
   logic [3:0] next_raw;

   // ---------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // slave clock is oversampled, hence the 12x limit on its rate
   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_meta <= 1'b0;
         clk_sync <= 1'b0;
         clk_prev <= 1'b0;
         fss_meta <= 1'b1;
         fss_sync <= 1'b1;
         rx_meta <= 1'b0;
         rx_sync <= 1'b0;
      end
      else
      begin
         clk_meta <= serial_clock_in;
         clk_sync <= clk_meta;
         clk_prev <= clk_sync;
         fss_meta <= frame_select_line_in;
         fss_sync <= fss_meta;
         rx_meta <= serial_rx_line_in;
         rx_sync <= rx_meta;
      end
   end

   // ---------------------------------------------------------
   // bit rate: half period = prescale/2 * (1 + rate)
   // ---------------------------------------------------------
   assign half_pre = (clock_prescale_divisor_in[7:1] == 7'h00) ? 7'h01 :
      clock_prescale_divisor_in[7:1];

   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_cnt <= '0;
         rate_cnt <= '0;
         half_tick <= 1'b0;
      end
      else if (!enable_in)
      begin
         pre_cnt <= '0;
         rate_cnt <= '0;
         half_tick <= 1'b0;
      end
      else
      begin
         half_tick <= 1'b0;
         if (pre_cnt == half_pre - 7'h01)
         begin
            pre_cnt <= '0;
            if (rate_cnt == serial_clock_rate_in)
            begin
               rate_cnt <= '0;
               half_tick <= 1'b1;
            end
            else
               rate_cnt <= rate_cnt + 8'h01;
         end
         else
            pre_cnt <= pre_cnt + 7'h01;
      end
   end

   // ---------------------------------------------------------
   // edge events and format decode
   // ---------------------------------------------------------
   assign size_m1 = (data_size_m1_in < ssp_pkg::MIN_SIZE_M1) ? ssp_pkg::MIN_SIZE_M1 :
      data_size_m1_in;
   assign last_idx = {1'b0, size_m1} +
      ((format_in == ssp_pkg::FMT_HALF) ? ssp_pkg::REPLY_START : 5'h00);
   assign idle_pol = (format_in == ssp_pkg::FMT_SPI) & clock_polarity_in;
   assign launch_first = (format_in == ssp_pkg::FMT_PULSED) |
      ((format_in == ssp_pkg::FMT_SPI) & clock_phase_in);
   assign ev1 = master_in ? (half_tick & ~half_b) :
      ((clk_sync ^ clk_prev) & (clk_sync != idle_pol));
   assign ev2 = master_in ? (half_tick & half_b) :
      ((clk_sync ^ clk_prev) & (clk_sync == idle_pol));
   assign cap = (state == ssp_pkg::SSP_SHIFT) & (launch_first ? ev2 : ev1);
   assign launch = (state == ssp_pkg::SSP_SHIFT) & (launch_first ? ev1 : ev2);
   assign rx_bit = loopback_in ? serial_tx_line_out : rx_sync;

   assign load = (state == ssp_pkg::SSP_IDLE) & enable_in & (master_in ? tx_has :
      ((format_in == ssp_pkg::FMT_PULSED) ? (ev2 & fss_sync) : ~fss_sync));
   assign lead_done = (state == ssp_pkg::SSP_LEAD) & half_tick &
      ((format_in != ssp_pkg::FMT_PULSED) | half_b);
   assign last_bit = (state == ssp_pkg::SSP_SHIFT) & ev2 & (bit_idx == last_idx);
   assign abort = (state == ssp_pkg::SSP_SHIFT) & ~master_in &
      (format_in != ssp_pkg::FMT_PULSED) & fss_sync;
   assign tail_done = (state == ssp_pkg::SSP_TAIL) & (master_in ? half_tick :
      ((format_in == ssp_pkg::FMT_PULSED) | fss_sync));
   assign aligned = (format_in == ssp_pkg::FMT_HALF) ? {tx_word[7:0], 8'h00} :
      (tx_word << (ssp_pkg::MAX_SIZE_M1 - size_m1));

   // ---------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------
   always_comb
   begin
      next_state = state;
      if (!enable_in || abort)
         next_state = ssp_pkg::SSP_IDLE;
      else
         unique case (state)
            ssp_pkg::SSP_IDLE:
               if (load)
                  next_state = master_in ? ssp_pkg::SSP_LEAD : ssp_pkg::SSP_SHIFT;
            ssp_pkg::SSP_LEAD:
               if (lead_done)
                  next_state = ssp_pkg::SSP_SHIFT;
            ssp_pkg::SSP_SHIFT:
               if (last_bit)
                  next_state = ssp_pkg::SSP_TAIL;
            ssp_pkg::SSP_TAIL:
               if (tail_done)
                  next_state = ssp_pkg::SSP_IDLE;
         endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
         state <= ssp_pkg::SSP_IDLE;
      else
         state <= next_state;
   end

   // select, busy and the tx pad enable (slave or pulsed only) follow the next state so they line up with the clock
   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_select_line_out <= 1'b1;
         frame_select_line_oe_out <= 1'b0;
         serial_clock_oe_out <= 1'b0;
         serial_tx_line_oe_out <= 1'b0;
         busy_out <= 1'b0;
      end
      else
      begin
         if (format_in == ssp_pkg::FMT_PULSED)
            frame_select_line_out <= next_state == ssp_pkg::SSP_LEAD;
         else
            frame_select_line_out <= next_state == ssp_pkg::SSP_IDLE;
         frame_select_line_oe_out <= enable_in & master_in;
         serial_clock_oe_out <= enable_in & master_in;
         if (master_in && format_in != ssp_pkg::FMT_PULSED)
            serial_tx_line_oe_out <= enable_in;
         else
            serial_tx_line_oe_out <= enable_in & (next_state != ssp_pkg::SSP_IDLE);
         busy_out <= next_state != ssp_pkg::SSP_IDLE;
      end
   end

   // ---------------------------------------------------------
   // shifters and serial clock
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh <= '0;
         serial_tx_line_out <= 1'b0;
         rx_sh <= '0;
         bit_idx <= '0;
         half_b <= 1'b0;
         serial_clock_out <= 1'b0;
      end
      else
      begin
         if (load)
         begin
            bit_idx <= '0;
            half_b <= 1'b0;
            if (launch_first)
               tx_sh <= aligned;
            else
            begin
               tx_sh <= aligned << 1;
               serial_tx_line_out <= aligned[15];
            end
         end
         else if (lead_done)
         begin
            half_b <= 1'b0;
            serial_clock_out <= idle_pol;
         end
         else if (state == ssp_pkg::SSP_LEAD && half_tick)
         begin
            half_b <= 1'b1;
            serial_clock_out <= ~serial_clock_out;
         end
         else if (state == ssp_pkg::SSP_SHIFT)
         begin
            if (master_in && half_tick)
            begin
               half_b <= ~half_b;
               serial_clock_out <= ~serial_clock_out;
            end
            if (launch)
            begin
               serial_tx_line_out <= tx_sh[15];
               tx_sh <= tx_sh << 1;
            end
            if (cap && (format_in != ssp_pkg::FMT_HALF || bit_idx >= ssp_pkg::REPLY_START))
               rx_sh <= {rx_sh[14:0], rx_bit};
            if (ev2)
               bit_idx <= bit_idx + 5'h01;
         end
         else
         begin
            serial_clock_out <= idle_pol;
            if (tail_done)
               serial_tx_line_out <= 1'b0;
         end
      end
   end

   // word is taken a cycle after the last trailing edge, so trailing-edge capture modes keep their last bit
   assign rx_word = rx_sh & (16'hffff >> (ssp_pkg::MAX_SIZE_M1 - size_m1));

   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
         rx_push <= 1'b0;
      else
         rx_push <= last_bit;
   end

   // ---------------------------------------------------------
   // fifos
   // ---------------------------------------------------------
   ssp_fifo #(
      .WIDTH(ssp_pkg::WORD_W),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_tx_fifo (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .in_data_in(tx_data_in),
      .out_valid_out(tx_has),
      .out_ready_in(load),
      .out_data_out(tx_word),
      .count_out(tx_count)
   );

   ssp_fifo #(
      .WIDTH(ssp_pkg::WORD_W),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_rx_fifo (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .in_valid_in(rx_push),
      .in_ready_out(rx_space),
      .in_data_in(rx_word),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_data_out),
      .count_out(rx_count)
   );

   // ---------------------------------------------------------
   // status and request
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
         idle_cnt <= '0;
      else if (state != ssp_pkg::SSP_IDLE || !rx_valid_out)
         idle_cnt <= '0;
      else if (half_tick && idle_cnt != ssp_pkg::TIMEOUT_HALVES)
         idle_cnt <= idle_cnt + 7'h01;
   end

   // a set in the same cycle as a clear wins
   always_comb
   begin
      next_raw = raw_interrupt_status_out;
      if (status_clear_in[ssp_pkg::ST_OVERRUN])
         next_raw[ssp_pkg::ST_OVERRUN] = 1'b0;
      if (status_clear_in[ssp_pkg::ST_TIMEOUT])
         next_raw[ssp_pkg::ST_TIMEOUT] = 1'b0;
      if (rx_push && !rx_space)
         next_raw[ssp_pkg::ST_OVERRUN] = 1'b1;
      if (idle_cnt == ssp_pkg::TIMEOUT_HALVES && rx_valid_out)
         next_raw[ssp_pkg::ST_TIMEOUT] = 1'b1;
      next_raw[ssp_pkg::ST_RX_SERVICE] = rx_count >= HALF_LEVEL;
      next_raw[ssp_pkg::ST_TX_SERVICE] = tx_count <= HALF_LEVEL;
   end

   always_ff @(posedge mclk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_interrupt_status_out <= '0;
         masked_interrupt_status_out <= '0;
         irq_out <= 1'b0;
      end
      else
      begin
         raw_interrupt_status_out <= next_raw;
         masked_interrupt_status_out <= next_raw & interrupt_mask_in;
         irq_out <= |(next_raw & interrupt_mask_in);
      end
   end
endmodule

// *** rtl/ssp_pkg.sv ***
// What this block does
// - frames carry 4 to 16 bits, msb first
// - first divider: even prescale 2 to 254
// - second divider: one plus rate, 1 to 256
// - transmit words wait in 16x8 fifo
// - received words wait in 16x8 fifo
// - receive pin registered before fifo load
// - four events ored into one request
// - mask bit 1 lets its event through
// - raw and masked status both readable
// - serial clock idle unless transferring
// - time-out flags idle clock with data held
// - spi and half-duplex select active low
// - pulsed format: one-period high frame pulse
// - half-duplex sends 8-bit command, receives reply from bit 9 on
// - pulsed idle: clock, select low, tx released
// - pulsed start: pulse select, load shifter
// - pulsed: msb out on next rising edge
// - pulsed: received word stored after lsb
// - loopback test mode, master or slave
// - spi idle clock level follows polarity
// - spi phase picks first or second edge
package ssp_pkg;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 8;
   // -------------------------------------------------
   // frame formats
   // -------------------------------------------------
   localparam logic [1:0] FMT_PULSED = 2'h0;
   localparam logic [1:0] FMT_SPI = 2'h1;
   localparam logic [1:0] FMT_HALF = 2'h2;
   localparam logic [3:0] MIN_SIZE_M1 = 4'h3;
   localparam logic [3:0] MAX_SIZE_M1 = 4'hf;
   localparam logic [4:0] REPLY_START = 5'h09;
   // -------------------------------------------------
   // status bit positions
   // -------------------------------------------------
   localparam int ST_OVERRUN = 0;
   localparam int ST_TIMEOUT = 1;
   localparam int ST_RX_SERVICE = 2;
   localparam int ST_TX_SERVICE = 3;
   localparam logic [6:0] TIMEOUT_HALVES = 7'h40;
   typedef enum logic [1:0]
   {
      SSP_IDLE = 2'b00,
      SSP_LEAD = 2'b01,
      SSP_SHIFT = 2'b11,
      SSP_TAIL = 2'b10
   } ssp_state_t;
endpackage

// *** testbench/ssp_props.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------
// port checker
// ---------------------------------------------------------
module ssp_props (
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // configuration
   input wire logic enable_in,
   input wire logic master_in,
   input wire logic [1:0] format_in,
   input wire logic clock_polarity_in,
   input wire logic [3:0] interrupt_mask_in,
   input wire logic [1:0] status_clear_in,
   // status
   input wire logic rx_valid_out,
   input wire logic [3:0] raw_interrupt_status_out,
   input wire logic [3:0] masked_interrupt_status_out,
   input wire logic irq_out,
   input wire logic busy_out,
   // serial pins
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe_out,
   input wire logic frame_select_line_out,
   input wire logic serial_tx_line_oe_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);
   // idle windows look one cycle back so a frame start never lands in them
   sequence s_spi_idle;
      (enable_in && master_in && format_in == ssp_pkg::FMT_SPI && !busy_out
       && $stable(clock_polarity_in))[*3] ##1 !busy_out;
   endsequence
   sequence s_pls_idle;
      (enable_in && master_in && format_in == ssp_pkg::FMT_PULSED && !busy_out)[*3]
       ##1 !busy_out;
   endsequence
   sequence s_irq_settled;
      ($stable(interrupt_mask_in) && $stable(raw_interrupt_status_out))[*3];
   endsequence
   property p_spi_clk_idle;
      s_spi_idle |-> $past(serial_clock_out) == $past(clock_polarity_in);
   endproperty
   a_spi_clk_idle: assert property (p_spi_clk_idle) else $error("idle clock level wrong");
   property p_spi_sel_idle;
      s_spi_idle |-> $past(frame_select_line_out);
   endproperty
   a_spi_sel_idle: assert property (p_spi_sel_idle) else $error("select low while idle");
   property p_spi_sel_act;
      $rose(busy_out) && master_in && format_in == ssp_pkg::FMT_SPI
       |-> ##[0:2] !frame_select_line_out;
   endproperty
   a_spi_sel_act: assert property (p_spi_sel_act) else $error("select not low in frame");
   property p_pls_idle;
      s_pls_idle |-> $past(!serial_clock_out && !frame_select_line_out
                           && !serial_tx_line_oe_out);
   endproperty
   a_pls_idle: assert property (p_pls_idle) else $error("pulsed idle pins wrong");
   property p_pls_pulse;
      master_in && format_in == ssp_pkg::FMT_PULSED && $rose(frame_select_line_out)
       |-> frame_select_line_out throughout ##[0:600] $rose(serial_clock_out);
   endproperty
   a_pls_pulse: assert property (p_pls_pulse) else $error("frame pulse without clock");
   property p_mask;
      s_irq_settled |-> masked_interrupt_status_out
                        == (raw_interrupt_status_out & interrupt_mask_in);
   endproperty
   a_mask: assert property (p_mask) else $error("masked status wrong");
   property p_irq;
      s_irq_settled |-> irq_out == (|masked_interrupt_status_out);
   endproperty
   a_irq: assert property (p_irq) else $error("request not the or of sources");
   property p_ovr_hold;
      raw_interrupt_status_out[ssp_pkg::ST_OVERRUN] && !status_clear_in[0]
       |=> raw_interrupt_status_out[ssp_pkg::ST_OVERRUN];
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
   property p_to_data;
      $rose(raw_interrupt_status_out[ssp_pkg::ST_TIMEOUT]) |-> $past(rx_valid_out);
   endproperty
   a_to_data: assert property (p_to_data) else $error("time-out with empty store");
   property p_clk_oe;
      ($stable(enable_in) && $stable(master_in))[*4]
       |-> serial_clock_oe_out == (enable_in && master_in);
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock pad enable wrong");
endmodule

bind ssp_top ssp_props u_props (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .enable_in(enable_in), .master_in(master_in),
   .format_in(format_in), .clock_polarity_in(clock_polarity_in),
   .interrupt_mask_in(interrupt_mask_in), .status_clear_in(status_clear_in),
   .rx_valid_out(rx_valid_out), .raw_interrupt_status_out(raw_interrupt_status_out),
   .masked_interrupt_status_out(masked_interrupt_status_out), .irq_out(irq_out),
   .busy_out(busy_out), .serial_clock_out(serial_clock_out),
   .serial_clock_oe_out(serial_clock_oe_out), .frame_select_line_out(frame_select_line_out),
   .serial_tx_line_oe_out(serial_tx_line_oe_out)
);

// *** testbench/ssp_spi_peer.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------
// spi peer with a fixed reply
// ---------------------------------------------------------
module ssp_spi_peer (
   // serial pins
   input wire logic sclk_in,
   input wire logic sel_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   // setup and result
   input wire logic pol_in,
   input wire logic pha_in,
   input wire logic [3:0] size_m1_in,
   input wire logic [15:0] reply_in,
   output logic [15:0] got_out
);
   int idx;
   initial
   begin
      miso_out = 1'b0;
      got_out = 16'h0000;
      idx = 0;
   end
   // phase 0 needs the msb out before the first edge
   always @(negedge sel_n_in)
   begin
      got_out = 16'h0000;
      idx = int'(size_m1_in);
      if (!pha_in)
      begin
         miso_out = reply_in[idx];
         idx--;
      end
   end
   // released line shows the inverse, never a stale bit
   always @(posedge sel_n_in)
      miso_out = ~miso_out;
   // capture on leading edge for phase 0, trailing for phase 1
   always @(sclk_in)
   begin
      if (!sel_n_in && ((sclk_in != pol_in) ^ pha_in))
         got_out = {got_out[14:0], mosi_in};
      else if (!sel_n_in && idx >= 0)
      begin
         miso_out = reply_in[idx];
         idx--;
      end
   end
endmodule

// *** testbench/sync_serial_port_bench.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------
// bench
// ---------------------------------------------------------
module sync_serial_port_bench;
   logic mclk_in;
   logic nrst_in = 0, enable_in = 0, master_in = 1, clock_polarity_in = 0;
   logic clock_phase_in = 0, loopback_in = 1, tx_valid_in = 0, rx_ready_in = 0;
   logic serial_clock_in = 1, frame_select_line_in = 1;
   logic [1:0] format_in = ssp_pkg::FMT_SPI, status_clear_in = 2'h0;
   logic [3:0] data_size_m1_in = 4'h7, interrupt_mask_in = 4'h0;
   logic [7:0] clock_prescale_divisor_in = 8'h08, serial_clock_rate_in = 8'h00;
   logic [15:0] tx_data_in = 16'h0000;
   logic tx_ready_out, rx_valid_out, irq_out, busy_out, serial_clock_out, fs_out, tx_line;
   logic rx_line;
   logic [3:0] raw_st, msk_st;
   logic [15:0] rx_data_out, peer_got;
   int n_errors = 0, num_checks = 0;

   ssp_top dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .enable_in(enable_in),
      .master_in(master_in), .format_in(format_in), .data_size_m1_in(data_size_m1_in),
      .clock_polarity_in(clock_polarity_in), .clock_phase_in(clock_phase_in),
      .loopback_in(loopback_in), .clock_prescale_divisor_in(clock_prescale_divisor_in),
      .serial_clock_rate_in(serial_clock_rate_in), .interrupt_mask_in(interrupt_mask_in),
      .status_clear_in(status_clear_in), .tx_valid_in(tx_valid_in),
      .tx_ready_out(tx_ready_out), .tx_data_in(tx_data_in), .rx_valid_out(rx_valid_out),
      .rx_ready_in(rx_ready_in), .rx_data_out(rx_data_out),
      .raw_interrupt_status_out(raw_st), .masked_interrupt_status_out(msk_st),
      .irq_out(irq_out), .busy_out(busy_out), .serial_clock_in(serial_clock_in),
      .serial_clock_out(serial_clock_out), .serial_clock_oe_out(),
      .frame_select_line_in(frame_select_line_in), .frame_select_line_out(fs_out),
      .frame_select_line_oe_out(), .serial_tx_line_out(tx_line),
      .serial_tx_line_oe_out(), .serial_rx_line_in(rx_line));

   ssp_spi_peer peer_u (.sclk_in(serial_clock_out), .sel_n_in(fs_out), .mosi_in(tx_line),
      .miso_out(rx_line), .pol_in(clock_polarity_in), .pha_in(clock_phase_in),
      .size_m1_in(data_size_m1_in), .reply_in(16'h0096), .got_out(peer_got));

   initial
   begin
      mclk_in = 0;
      forever #10 mclk_in = ~mclk_in;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #2;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // valid stays up across pushes so it is never lowered and raised in one step
   task automatic push(input logic [15:0] w);
      int k;
      k = 0;
      tx_data_in = w;
      tx_valid_in = 1;
      while (tx_ready_out !== 1'b1 && k < 2000)
      begin
         tick(1);
         k++;
      end
      tick(1);
   endtask

   task automatic pop(input logic [15:0] exp, input bit care);
      int k;
      k = 0;
      while (rx_valid_out !== 1'b1 && k < 2000)
      begin
         tick(1);
         k++;
      end
      if (care)
         chk(rx_data_out, exp);
      else
         chk({15'h0, rx_valid_out}, 16'h0001);
      rx_ready_in = 1;
      tick(1);
      rx_ready_in = 0;
      tick(1);
   endtask

   task automatic frame(input logic [15:0] w, input logic [15:0] exp, input bit care);
      push(w);
      tx_valid_in = 0;
      pop(exp, care);
   endtask

   task automatic settle;
      int q, k;
      q = 0;
      k = 0;
      while (q < 20 && k < 5000)
      begin
         tick(1);
         k++;
         q = busy_out ? 0 : q + 1;
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #(20 * 40000);
      n_errors++;
      give_verdict();
   end

   initial
   begin
      tick(4);
      chk({serial_clock_out, fs_out, tx_ready_out, rx_valid_out, irq_out, busy_out}, 16'h0018);
      tick(4);
      nrst_in = 1;
      tick(3);
      enable_in = 1;
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         data_size_m1_in = 4'(12'hf73 >> (4 * i));
         settle();
         frame(16'h3ca5, 16'h3ca5 & ~(16'hffff << (data_size_m1_in + 1)), 1);
      end
      $display("test loopback sizes done");
      loopback_in = 0;
      data_size_m1_in = 4'h7;
      for (int m = 0; m < 4; m++)
      begin
         {clock_polarity_in, clock_phase_in} = m[1:0];
         settle();
         frame(16'hff5a, 16'h0096, 1);
         chk(peer_got, 16'h005a);
      end
      $display("test spi modes done");
      loopback_in = 1;
      format_in = ssp_pkg::FMT_PULSED;
      data_size_m1_in = 4'hb;
      settle();
      frame(16'hfabc, 16'h0abc, 1);
      format_in = ssp_pkg::FMT_HALF;
      data_size_m1_in = 4'h7;
      settle();
      frame(16'h00c3, 16'h0000, 0);
      $display("test pulsed and half-duplex done");
      format_in = ssp_pkg::FMT_SPI;
      data_size_m1_in = 4'h3;
      settle();
      for (int i = 1; i <= 9; i++)
         push(i[15:0]);
      tx_valid_in = 0;
      settle();
      chk(raw_st, 16'h000d);
      chk({irq_out, msk_st}, 16'h0000);
      interrupt_mask_in = 4'h1;
      tick(3);
      chk({irq_out, msk_st}, 16'h0011);
      interrupt_mask_in = 4'h2;
      tick(400);
      chk({irq_out, msk_st}, 16'h0012);
      for (int i = 1; i <= 8; i++)
         pop(i[15:0], 1);
      status_clear_in = 2'h3;
      tick(1);
      status_clear_in = 2'h0;
      tick(2);
      chk({irq_out, raw_st}, 16'h0008);
      $display("test overrun and time-out done");
      master_in = 0;
      push(16'h0009);
      tx_valid_in = 0;
      frame_select_line_in = 0;
      repeat (8)
      begin
         tick(6);
         serial_clock_in = ~serial_clock_in;
      end
      tick(6);
      frame_select_line_in = 1;
      pop(16'h0009, 1);
      $display("test slave done");
      give_verdict();
   end
endmodule
